// >>> rtl/wdf_watchdog.sv
// watchdog timer with configuration bytes and software control register
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - bus width bit 6 high gives 16-bit external bus, low gives 8-bit.
// - power-up delay bit 0 high disables the power-up timer, low enables it.
// - fuse postscale code 000 gives 1:128, halving per step to 1:1.
// - fuse enable high runs watchdog; low hands control to software enable.
// - stack fault bit high lets full or underflow stack reset the device.
// - unimplemented bits of configuration bytes and control register read zero.
// - watchdog runs from its own free oscillator, also during sleep.
// - time-out while running resets the device, flagged as watchdog reset.
// - time-out while asleep wakes the device without reset.
// - every time-out clears the time-out status bit.
// - fuse-enabled watchdog cannot be disabled; software register ignored then.
// - with fuse disabled, software enable bit starts and stops the watchdog.
// - software postscale code 111 gives 1:128, down to 1:1 for 000.
// - postscale from fuse field when fuse-enabled, else from software field.
// - fuse-enabled with default fuse postscale (unprogrammed 111) applies 1:1.
// - clear instruction or sleep resets watchdog counter and postscaler.
// - clear with prescaler assigned zeroes count, keeps assignment.
// - software control register is read-write with enable and postscale.
// - entering sleep clears power-down status and sets time-out status.
module wdf_watchdog
    import wdf_pkg::*;
#(
    parameter int BASE_CYCLES = wdf_pkg::BASE_PERIOD_CYCLES,
    parameter int RC_DIV      = wdf_pkg::RC_DIVIDE,
    parameter int POWERUP_DELAY_TIMER_CYCLES = wdf_pkg::POWERUP_DELAY_CYC
) (
    // clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESETN,
    // configuration table read and program port
    input  wire logic        i_cfg_rd,
    input  wire logic        i_cfg_wr,
    input  wire logic [21:0] i_cfg_addr,
    input  wire logic [7:0]  i_cfg_wdata,
    output logic      [7:0]  o_cfg_rdata,
    output logic             o_cfg_rvalid,
    // software control register port
    input  wire logic        i_ctl_wr,
    input  wire logic [7:0]  i_ctl_wdata,
    output logic      [7:0]  o_ctl_rdata,
    // cpu events
    input  wire logic        i_clear_watchdog_instr,
    input  wire logic        i_sleep_instr,
    input  wire logic        i_prescaler_assigned,
    input  wire logic        i_stack_fault,
    input  wire logic        i_status_clear,
    // device effects
    output logic             o_bus_width_select,
    output logic             o_powerup_delay_active,
    output logic             o_watchdog_reset,
    output logic             o_stack_reset,
    output logic             o_wake,
    output logic             o_sleeping,
    output logic             o_prescaler_clear,
    output logic             o_timeout_status,
    output logic             o_powerdown_status,
    output logic             o_running
);
    import wdf_pkg::*;

    // ------------------------------------------------------------
    // configuration byte storage
    // ------------------------------------------------------------
    logic [7:0]  fuse_rdata;
    logic [2:0]  fuse_idx;
    logic [7:0]  bwp_r;
    logic [7:0]  wdf_r;
    logic [7:0]  stk_r;
    logic        rd_pend_r;
    logic [2:0]  rd_idx_r;
    logic [1:0]  load_r;

    wire         in_cfg = (i_cfg_addr[21:3] == CONFIG_BASE[21:3]);
    assign fuse_idx     = load_r == 2'd0 ? ADDR_BUS_WIDTH_POWERUP_CONFIG[2:0]
                        : load_r == 2'd1 ? ADDR_WATCHDOG_FUSE_CONFIG[2:0]
                        : load_r == 2'd2 ? ADDR_STACK_RESET_CONFIG[2:0]
                        : i_cfg_addr[2:0];

    wdf_fuse_mem #(.DEPTH(CONFIG_DEPTH), .AW(3)) u_mem (
        .i_clk    (I_SYS_CLK),
        .i_resetn (I_RESETN),
        .i_we     (i_cfg_wr && in_cfg),
        .i_waddr  (i_cfg_addr[2:0]),
        .i_wdata  (i_cfg_wdata),
        .i_raddr  (fuse_idx),
        .o_rdata  (fuse_rdata)
    );

    // mask a configuration byte to its implemented bits
    function automatic logic [7:0] cfg_mask(input logic [2:0] idx, input logic [7:0] d);
        logic [7:0] m;
        m = 8'h00;
        if (idx == ADDR_BUS_WIDTH_POWERUP_CONFIG[2:0])
            m = MASK_BUS_WIDTH_POWERUP;
        else if (idx == ADDR_WATCHDOG_FUSE_CONFIG[2:0])
            m = MASK_WATCHDOG_FUSE;
        else if (idx == ADDR_STACK_RESET_CONFIG[2:0])
            m = MASK_STACK_RESET;
        return d & m;
    endfunction : cfg_mask

    // ------------------------------------------------------------
    // fuse shadow load after reset, then table reads
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            load_r       <= 2'd0;
            bwp_r        <= 8'h00;
            wdf_r        <= 8'h00;
            stk_r        <= 8'h00;
            rd_pend_r    <= 1'b0;
            rd_idx_r     <= 3'h0;
            o_cfg_rdata  <= 8'h00;
            o_cfg_rvalid <= 1'b0;
        end
        else
        begin
            if (load_r != 2'd3)
                load_r <= load_r + 2'd1;
            if (load_r == 2'd1)
                bwp_r <= fuse_rdata & MASK_BUS_WIDTH_POWERUP;
            if (load_r == 2'd2)
                wdf_r <= fuse_rdata & MASK_WATCHDOG_FUSE;
            if (load_r == 2'd3 && !stk_r[STACK_RESERVED_BIT])
                stk_r <= fuse_rdata & MASK_STACK_RESET;
            rd_pend_r    <= i_cfg_rd && in_cfg && load_r == 2'd3;
            rd_idx_r     <= i_cfg_addr[2:0];
            o_cfg_rvalid <= rd_pend_r;
            o_cfg_rdata  <= rd_pend_r ? cfg_mask(rd_idx_r, fuse_rdata) : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------
    logic [7:0]  soft_ctl_r;
    wire         fuse_en   = wdf_r[FUSE_WATCHDOG_ENABLE_BIT];
    wire  [2:0]  fuse_ps   = wdf_r[FUSE_POSTSCALE_LSB +: 3];
    wire  [2:0]  soft_ps   = soft_ctl_r[SOFT_POSTSCALE_LSB +: 3];
    wire         soft_en   = soft_ctl_r[SOFT_WATCHDOG_ENABLE_BIT];
    wire         wdt_en    = fuse_en | soft_en;
    // fuse: 000 -> 2^7, soft: 111 -> 2^7
    wire  [2:0]  ps_log2   = fuse_en ? (POSTSCALE_MAX_LOG2 - fuse_ps)
                                     : soft_ps;
    wire         cfg_ready = (load_r == 2'd3);

    // ------------------------------------------------------------
    // software control register
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
            soft_ctl_r <= RESET_SOFT_CONTROL;
        else if (i_ctl_wr)
            soft_ctl_r <= i_ctl_wdata & MASK_SOFT_CONTROL;
    end

    // ------------------------------------------------------------
    // watchdog base counter and postscaler on oscillator ticks
    // ------------------------------------------------------------
    logic        rc_tick;
    logic [15:0] base_r;
    logic [7:0]  post_r;
    wdf_state_type state_r;

    wdf_rc_divider #(.DIVIDE(RC_DIV)) u_rc (
        .i_clk    (I_SYS_CLK),
        .i_resetn (I_RESETN),
        .o_tick   (rc_tick)
    );

    wire         run       = wdt_en && cfg_ready && state_r != WDF_RESET;
    wire         clr       = i_clear_watchdog_instr || (i_sleep_instr && state_r == WDF_RUN);
    wire         base_wrap = rc_tick && base_r == 16'(BASE_CYCLES - 1);
    wire  [7:0]  post_last = (8'h01 << ps_log2) - 8'h01;
    wire         timeout   = run && !clr && base_wrap && post_r >= post_last;

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            base_r <= 16'h0000;
            post_r <= 8'h00;
        end
        else if (clr || !run || timeout)
        begin
            base_r <= 16'h0000;
            post_r <= 8'h00;
        end
        else if (rc_tick)
        begin
            base_r <= base_wrap ? 16'h0000 : base_r + 16'h0001;
            if (base_wrap)
                post_r <= post_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // run, sleep and reset sequencing with status bits
    // ------------------------------------------------------------
    logic [15:0] powerup_delay_timer_r;
    wire         stack_hit = i_stack_fault && stk_r[STACK_FAULT_RESET_BIT] && cfg_ready;

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            state_r            <= WDF_RUN;
            o_watchdog_reset   <= 1'b0;
            o_stack_reset      <= 1'b0;
            o_wake             <= 1'b0;
            o_sleeping         <= 1'b0;
            o_prescaler_clear  <= 1'b0;
            o_timeout_status   <= 1'b1;
            o_powerdown_status <= 1'b1;
        end
        else
        begin
            o_wake            <= 1'b0;
            o_watchdog_reset  <= 1'b0;
            o_stack_reset     <= stack_hit;
            o_prescaler_clear <= i_clear_watchdog_instr && i_prescaler_assigned;
            case (state_r)
                WDF_RUN:
                begin
                    if (timeout)
                    begin
                        state_r          <= WDF_RESET;
                        o_watchdog_reset <= 1'b1;
                        o_timeout_status <= 1'b0;
                    end
                    else if (i_sleep_instr)
                    begin
                        state_r            <= WDF_SLEEP;
                        o_sleeping         <= 1'b1;
                        o_powerdown_status <= 1'b0;
                        o_timeout_status   <= 1'b1;
                    end
                    else if (i_status_clear)
                    begin
                        o_timeout_status   <= 1'b1;
                        o_powerdown_status <= 1'b1;
                    end
                end
                WDF_SLEEP:
                begin
                    if (timeout)
                    begin
                        state_r          <= WDF_RUN;
                        o_sleeping       <= 1'b0;
                        o_wake           <= 1'b1;
                        o_timeout_status <= 1'b0;
                    end
                end
                default:
                begin
                    state_r    <= WDF_RUN;
                    o_sleeping <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // power-up delay and static option outputs
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            powerup_delay_timer_r                 <= 16'h0000;
            o_powerup_delay_active <= 1'b1;
            o_bus_width_select     <= 1'b0;
            o_ctl_rdata            <= 8'h00;
            o_running              <= 1'b0;
        end
        else
        begin
            o_bus_width_select <= bwp_r[BUS_WIDTH_SELECT_BIT];
            o_ctl_rdata        <= soft_ctl_r;
            o_running          <= run;
            if (cfg_ready && powerup_delay_timer_r != 16'(POWERUP_DELAY_TIMER_CYCLES))
                powerup_delay_timer_r <= powerup_delay_timer_r + 16'h0001;
            o_powerup_delay_active <= !cfg_ready ||
                (!bwp_r[POWERUP_DELAY_DISABLE_BIT] && powerup_delay_timer_r != 16'(POWERUP_DELAY_TIMER_CYCLES));
        end
    end
endmodule : wdf_watchdog
`default_nettype wire

// >>> rtl/wdf_pkg.sv
// package of constants and types for the watchdog with configuration fuses
package wdf_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [21:0] ADDR_BUS_WIDTH_POWERUP_CONFIG = 22'h300002;
    localparam logic [21:0] ADDR_WATCHDOG_FUSE_CONFIG     = 22'h300003;
    localparam logic [21:0] ADDR_STACK_RESET_CONFIG       = 22'h300006;
    localparam logic [21:0] CONFIG_BASE                   = 22'h300000;
    localparam int          CONFIG_DEPTH                  = 8;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BUS_WIDTH_SELECT_BIT      = 6;
    localparam int POWERUP_DELAY_DISABLE_BIT = 0;
    localparam int FUSE_WATCHDOG_ENABLE_BIT  = 0;
    localparam int FUSE_POSTSCALE_LSB        = 1;
    localparam int STACK_FAULT_RESET_BIT     = 0;
    localparam int STACK_RESERVED_BIT        = 7;
    localparam int SOFT_WATCHDOG_ENABLE_BIT  = 0;
    localparam int SOFT_POSTSCALE_LSB        = 1;
    localparam int POWERDOWN_STATUS_BIT      = 2;
    localparam int TIMEOUT_STATUS_BIT        = 3;
    // ------------------------------------------------------------
    // implemented bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_BUS_WIDTH_POWERUP  = 8'h41;
    localparam logic [7:0] MASK_WATCHDOG_FUSE      = 8'h0F;
    localparam logic [7:0] MASK_STACK_RESET        = 8'h81;
    localparam logic [7:0] MASK_SOFT_CONTROL       = 8'h0F;
    localparam logic [7:0] RESET_SOFT_CONTROL      = 8'h00;
    localparam logic [7:0] UNPROG_BYTE             = 8'hFF;
    localparam logic [2:0] POSTSCALE_MAX_LOG2      = 3'h7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int BASE_PERIOD_CYCLES = 2304;
    localparam int RC_DIVIDE          = 4;
    localparam int POWERUP_DELAY_CYC  = 1024;
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        WDF_RUN   = 2'b00,
        WDF_SLEEP = 2'b01,
        WDF_RESET = 2'b11
    } wdf_state_type;
endpackage : wdf_pkg

// >>> rtl/wdf_fuse_mem.sv
// small configuration byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module wdf_fuse_mem #(
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_resetn,
    // programming port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [7:0]    i_wdata,
    // read port
    input  wire logic [AW-1:0] i_raddr,
    output logic      [7:0]    o_rdata
);
    // unprogrammed bytes read all ones; contents survive a device reset
    logic [7:0] mem_r [DEPTH] = '{default: 8'hFF};

    // ------------------------------------------------------------
    // storage, kept out of reset so programmed bytes persist
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_we)
            mem_r[i_waddr] <= i_wdata;
    end

    // ------------------------------------------------------------
    // registered read data
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_rdata <= 8'h00;
        else
            o_rdata <= mem_r[i_raddr];
    end
endmodule : wdf_fuse_mem
`default_nettype wire

// >>> rtl/wdf_rc_divider.sv
// divider that stands in for the free-running watchdog oscillator
`timescale 1ns/1ps
`default_nettype none
module wdf_rc_divider #(
    parameter int DIVIDE = 4
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // tick out
    output logic      o_tick
);
    logic [15:0] cnt_r;
    wire         wrap = (cnt_r == 16'(DIVIDE - 1));

    // ------------------------------------------------------------
    // free running, no enable or clear input
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cnt_r  <= 16'h0000;
            o_tick <= 1'b0;
        end
        else
        begin
            cnt_r  <= wrap ? 16'h0000 : cnt_r + 16'h0001;
            o_tick <= wrap;
        end
    end
endmodule : wdf_rc_divider
`default_nettype wire

// >>> tb/wdf_watchdog_assertions.sv
// port-level checker of the watchdog block
`timescale 1ns/1ps
`default_nettype none
module wdf_watchdog_chk (
    // clock and reset
    input wire logic        I_SYS_CLK,
    input wire logic        I_RESETN,
    // inputs
    input wire logic        i_cfg_rd,
    input wire logic [21:0] i_cfg_addr,
    input wire logic        i_ctl_wr,
    input wire logic [7:0]  i_ctl_wdata,
    input wire logic        i_clear_watchdog_instr,
    input wire logic        i_sleep_instr,
    input wire logic        i_prescaler_assigned,
    input wire logic        i_stack_fault,
    // outputs
    input wire logic        o_cfg_rvalid,
    input wire logic [7:0]  o_ctl_rdata,
    input wire logic        o_watchdog_reset,
    input wire logic        o_stack_reset,
    input wire logic        o_wake,
    input wire logic        o_sleeping,
    input wire logic        o_prescaler_clear,
    input wire logic        o_timeout_status,
    input wire logic        o_powerdown_status
);
    import wdf_pkg::*;
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);
    a_stack_cause: assert property (o_stack_reset |-> $past(i_stack_fault))
        else $error("stack reset without stack fault");
    a_wake_status: assert property (o_wake |=> !o_sleeping && !o_timeout_status)
        else $error("wake left sleep or status set");
    a_reset_awake: assert property (o_watchdog_reset |-> !$past(o_sleeping))
        else $error("watchdog reset while asleep");
    a_reset_status: assert property (o_watchdog_reset |=> !o_timeout_status)
        else $error("time-out status not cleared");
    a_sleep_entry: assert property (i_sleep_instr && !o_sleeping |=>
        o_sleeping && !o_powerdown_status && o_timeout_status)
        else $error("sleep entry status wrong");
    a_clear_presc: assert property (i_clear_watchdog_instr && i_prescaler_assigned |=>
        o_prescaler_clear)
        else $error("prescaler not cleared");
    a_presc_cause: assert property (o_prescaler_clear |->
        $past(i_clear_watchdog_instr) && $past(i_prescaler_assigned))
        else $error("prescaler clear without cause");
    a_ctl_mirror: assert property (i_ctl_wr |->
        ##2 o_ctl_rdata == ($past(i_ctl_wdata, 2) & MASK_SOFT_CONTROL))
        else $error("control register read-back wrong");
    a_rvalid_cause: assert property (o_cfg_rvalid |-> $past(i_cfg_rd, 2) &&
        $past(i_cfg_addr, 2) inside {[CONFIG_BASE:CONFIG_BASE + 22'h7]})
        else $error("config read answer without request");
    cover property (o_wake);
    cover property (o_watchdog_reset ##1 !o_timeout_status);
    cover property (o_stack_reset);
endmodule : wdf_watchdog_chk
bind wdf_watchdog wdf_watchdog_chk wdf_watchdog_chk_inst (.*);
`default_nettype wire

// >>> tb/tb.sv
// self-checking testbench of the watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wdf_pkg::*;
    localparam int T0 = 8;
    logic        sys_clk, sys_resetn, i_cfg_rd, i_cfg_wr, i_ctl_wr, rd_valid;
    logic [21:0] i_cfg_addr;
    logic [7:0]  i_cfg_wdata, i_ctl_wdata, o_cfg_rdata, o_ctl_rdata, rd_data;
    logic        i_clear_watchdog_instr, i_sleep_instr, i_prescaler_assigned, i_stack_fault;
    logic        i_status_clear, o_cfg_rvalid, o_bus_width_select, o_powerup_delay_active;
    logic        o_watchdog_reset, o_stack_reset, o_wake, o_sleeping, o_prescaler_clear;
    logic        o_timeout_status, o_powerdown_status, o_running;
    int          fail_count, compares, cycles, n_rst, n_stk, n_wake, n_psc, n, b;
    // ----------
    // design
    // ----------
    wdf_watchdog #(.BASE_CYCLES(4), .RC_DIV(2), .POWERUP_DELAY_TIMER_CYCLES(32)) wdf_watchdog_inst (
        .I_SYS_CLK(sys_clk), .I_RESETN(sys_resetn), .i_cfg_rd, .i_cfg_wr, .i_cfg_addr,
        .i_cfg_wdata, .o_cfg_rdata, .o_cfg_rvalid, .i_ctl_wr, .i_ctl_wdata, .o_ctl_rdata,
        .i_clear_watchdog_instr, .i_sleep_instr, .i_prescaler_assigned, .i_stack_fault,
        .i_status_clear, .o_bus_width_select, .o_powerup_delay_active, .o_watchdog_reset,
        .o_stack_reset, .o_wake, .o_sleeping, .o_prescaler_clear, .o_timeout_status,
        .o_powerdown_status, .o_running);
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // event counters and hang limit
    always @(posedge sys_clk)
    begin
        cycles++;
        n_rst += int'(o_watchdog_reset === 1'b1);
        n_stk += int'(o_stack_reset === 1'b1);
        n_wake += int'(o_wake === 1'b1);
        n_psc += int'(o_prescaler_clear === 1'b1);
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    // ----------
    // tasks
    // ----------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit
    task automatic chk_cnt(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_cnt
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
        @(negedge sys_clk);
    endtask : pulse
    task automatic do_reset;
        sys_resetn = 1'b0;
        repeat (20) @(negedge sys_clk);
        sys_resetn = 1'b1;
        repeat (6) @(negedge sys_clk);
    endtask : do_reset
    task automatic cfg_rd(input logic [21:0] a, output logic v, output logic [7:0] d);
        i_cfg_addr = a;
        pulse(i_cfg_rd);
        v = o_cfg_rvalid;
        d = o_cfg_rdata;
        @(negedge sys_clk);
    endtask : cfg_rd
    task automatic cfg_wr(input logic [21:0] a, input logic [7:0] d);
        i_cfg_addr = a;
        i_cfg_wdata = d;
        pulse(i_cfg_wr);
    endtask : cfg_wr
    task automatic ctl_wr(input logic [7:0] d);
        i_ctl_wdata = d;
        pulse(i_ctl_wr);
        @(negedge sys_clk);
    endtask : ctl_wr
    task automatic wait_rst(input int lim, output int k);
        int base;
        base = n_rst;
        k = 0;
        while (n_rst == base && k < lim)
        begin
            @(negedge sys_clk);
            k++;
        end
    endtask : wait_rst
    // ----------
    // scenarios
    // ----------
    task automatic test_defaults;
        cfg_rd(ADDR_BUS_WIDTH_POWERUP_CONFIG, rd_valid, rd_data);
        chk_bit(rd_valid, 1'b1);
        chk_byte(rd_data, 8'h41);
        cfg_rd(ADDR_WATCHDOG_FUSE_CONFIG, rd_valid, rd_data);
        chk_byte(rd_data, 8'h0F);
        cfg_rd(ADDR_STACK_RESET_CONFIG, rd_valid, rd_data);
        chk_byte(rd_data, 8'h81);
        cfg_rd(22'h300010, rd_valid, rd_data);
        chk_bit(rd_valid, 1'b0);
        chk_bit(o_bus_width_select, 1'b1);
        chk_bit(o_powerup_delay_active, 1'b0);
        chk_byte(o_ctl_rdata, 8'h00);
        $display("test_defaults done");
    endtask : test_defaults
    task automatic test_fuse_run;
        wait_rst(50, n);
        wait_rst(50, n);
        chk_cnt(n, T0, T0 + 4);
        chk_bit(o_timeout_status, 1'b0);
        ctl_wr(8'h00);
        wait_rst(50, n);
        wait_rst(50, n);
        chk_cnt(n, T0, T0 + 4);
        ctl_wr(8'h0F);
        wait_rst(50, n);
        wait_rst(50, n);
        chk_cnt(n, T0, T0 + 4);
        @(negedge sys_clk);
        chk_bit(o_running, 1'b1);
        ctl_wr(8'h00);
        $display("test_fuse_run done");
    endtask : test_fuse_run
    task automatic test_clear;
        wait_rst(50, n);
        i_prescaler_assigned = 1'b1;
        b = n_rst;
        n = n_psc;
        repeat (15)
        begin
            pulse(i_clear_watchdog_instr);
            repeat (2) @(negedge sys_clk);
        end
        chk_cnt(n_rst - b, 0, 0);
        i_prescaler_assigned = 1'b0;
        pulse(i_clear_watchdog_instr);
        @(negedge sys_clk);
        chk_cnt(n_psc - n, 15, 15);
        n = n_stk;
        pulse(i_stack_fault);
        @(negedge sys_clk);
        chk_cnt(n_stk - n, 1, 1);
        $display("test_clear done");
    endtask : test_clear
    task automatic test_sleep;
        wait_rst(50, n);
        b = n_rst;
        n = n_wake;
        pulse(i_sleep_instr);
        chk_bit(o_sleeping, 1'b1);
        chk_bit(o_powerdown_status, 1'b0);
        chk_bit(o_timeout_status, 1'b1);
        repeat (T0 + 3) @(negedge sys_clk);
        chk_cnt(n_wake - n, 1, 1);
        chk_cnt(n_rst - b, 0, 0);
        chk_bit(o_sleeping, 1'b0);
        chk_bit(o_timeout_status, 1'b0);
        pulse(i_status_clear);
        chk_bit(o_timeout_status, 1'b1);
        chk_bit(o_powerdown_status, 1'b1);
        $display("test_sleep done");
    endtask : test_sleep
    task automatic test_soft;
        cfg_wr(ADDR_BUS_WIDTH_POWERUP_CONFIG, 8'h00);
        cfg_wr(ADDR_WATCHDOG_FUSE_CONFIG, 8'h0E);
        cfg_wr(ADDR_STACK_RESET_CONFIG, 8'h80);
        do_reset();
        chk_bit(o_powerup_delay_active, 1'b1);
        cfg_rd(ADDR_STACK_RESET_CONFIG, rd_valid, rd_data);
        chk_byte(rd_data, 8'h80);
        chk_bit(o_bus_width_select, 1'b0);
        b = n_rst;
        repeat (40) @(negedge sys_clk);
        chk_bit(o_powerup_delay_active, 1'b0);
        chk_cnt(n_rst - b, 0, 0);
        n = n_stk;
        pulse(i_stack_fault);
        @(negedge sys_clk);
        chk_cnt(n_stk - n, 0, 0);
        ctl_wr(8'hF7);
        chk_byte(o_ctl_rdata, 8'h07);
        wait_rst(200, n);
        chk_cnt(n, 8 * T0 - 5, 8 * T0 + 2);
        ctl_wr(8'h00);
        ctl_wr(8'h01);
        wait_rst(50, n);
        wait_rst(50, n);
        chk_cnt(n, T0, T0 + 4);
        ctl_wr(8'h00);
        b = n_rst;
        repeat (100) @(negedge sys_clk);
        chk_cnt(n_rst - b, 0, 0);
        cfg_wr(ADDR_WATCHDOG_FUSE_CONFIG, 8'h0D);
        do_reset();
        wait_rst(50, n);
        wait_rst(50, n);
        chk_cnt(n, 2 * T0, 2 * T0 + 4);
        $display("test_soft done");
    endtask : test_soft
    task automatic test_done;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial
    begin
        {i_cfg_rd, i_cfg_wr, i_ctl_wr, i_clear_watchdog_instr, i_sleep_instr} = '0;
        {i_prescaler_assigned, i_stack_fault, i_status_clear} = '0;
        {i_cfg_addr, i_cfg_wdata, i_ctl_wdata} = '0;
        do_reset();
        test_defaults();
        test_fuse_run();
        test_clear();
        test_sleep();
        test_soft();
        test_done();
    end
endmodule : tb
`default_nettype wire
